//--- hw/smc_sleep_ctrl.sv
`timescale 1ns/1ns
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_DEFAULT
) (
  input  wire logic                 clk,              // 100 MHz clock
  input  wire logic                 rst_n,            // Sync reset, low
  input  wire logic                 sleepInstr,       // Sleep instruction pulse
  input  wire logic                 sleepArmBit,      // Sleep arm bit
  input  wire logic [2:0]           sleepModeCode,    // Mode select
  input  wire logic                 crystalSelected,  // Crystal clock option
  input  wire logic                 timer2AsyncClockSelect, // Timer 2 async
  input  wire logic                 timer2OvfIrqEn,   // Timer 2 overflow enable
  input  wire logic                 timer2CmpIrqEn,   // Timer 2 compare enable
  input  wire logic                 globalIrqEn,      // Global interrupt enable
  input  wire smc_wake_t            wakeIn,           // Wake sources
  input  wire logic                 converterEn,      // Converter enable
  input  wire logic                 comparatorPowerOffBit, // Comparator off
  input  wire logic                 comparatorUsesRef,// Comparator uses ref
  input  wire logic [2:0]           brownoutLevelFuses, // BOD level
  input  wire logic                 watchdogEn,       // Watchdog enable
  input  wire logic [DIDR_W-1:0]    digitalInputDisableZero, // Disable reg 0
  input  wire logic [DIDR_W-1:0]    digitalInputDisableOne,  // Disable reg 1
  input  wire logic [15:0]          wakeNeededPins,   // Pins used for wake
  input  wire logic                 onchipDebugEnableFuse, // Debug fuse
  input  wire logic                 scanPortEnableFuse,    // Scan port fuse
  input  wire logic                 scanPortDisableBit,    // Scan port off bit
  input  wire logic                 tapShifting,      // TAP shifting data
  input  wire logic                 tapTdoData,       // TAP data out
  output smc_clk_en_t               clkEnOut,         // Clock enables
  output logic                      converterEnOut,   // Converter power
  output logic                      convStartOut,     // Conversion start pulse
  output logic                      convExtendedOut,  // Next conv extended
  output logic                      comparatorEnOut,  // Comparator power
  output logic                      refEnOut,         // Voltage reference on
  output logic                      brownoutEnOut,    // Brown-out detector on
  output logic                      watchdogEnOut,    // Watchdog on
  output logic [15:0]               inputBufEnOut,    // Digital input buffers
  output logic                      scanPortEnOut,    // Test access port on
  output logic                      tdoOut,           // TDO value
  output logic                      tdoOe,            // TDO drive enable
  output logic                      cpuHaltOut,       // Core halted
  output logic                      irqServiceOut,    // Resume with interrupt
  output logic [2:0]                activeModeOut     // Mode being slept
);

  initial begin
    if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << CNT_W))
      $error("STARTUP_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // Mode resolution
  // ---------------------------------------------------------------
  logic       modeValid;
  logic [2:0] effMode;
  always_comb begin
    modeValid = 1'b1;
    effMode   = sleepModeCode;
    unique case (sleepModeCode)
      MODE_IDLE, MODE_NOISE_RED, MODE_PWR_DOWN, MODE_PWR_SAVE: ;
      MODE_STANDBY: if (!crystalSelected) effMode = MODE_PWR_DOWN;
      default: modeValid = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Wake qualification per mode
  // ---------------------------------------------------------------
  logic extWake;
  logic t2Wake;
  logic wakeEvent;
  logic irqWake;
  // Upper lines only by level, lower lines by any event
  assign extWake = (|wakeIn.extIrqEdge[3:0]) | (|wakeIn.extIrqLevel);
  assign t2Wake  = globalIrqEn & ((wakeIn.timer2Ovf & timer2OvfIrqEn) |
                                  (wakeIn.timer2Cmp & timer2CmpIrqEn));

  always_comb begin
    irqWake = 1'b0;
    unique case (activeModeOut)
      MODE_IDLE: irqWake = (|wakeIn.extIrqEdge) | (|wakeIn.extIrqLevel) | wakeIn.twiMatch |
                           t2Wake | wakeIn.selfProgReady | wakeIn.eepromReady |
                           wakeIn.convDone | wakeIn.otherIo;
      MODE_NOISE_RED: irqWake = wakeIn.convDone | extWake | wakeIn.twiMatch | t2Wake |
                                wakeIn.selfProgReady | wakeIn.eepromReady;
      MODE_PWR_SAVE: irqWake = extWake | wakeIn.twiMatch |
                               (t2Wake & timer2AsyncClockSelect);
      default: irqWake = extWake | wakeIn.twiMatch;
    endcase
    wakeEvent = irqWake | wakeIn.resetReq;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  smc_state_t      state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [2:0]      mode_reg, mode_next;
  logic            irqPend_reg, irqPend_next;
  logic            convStart_reg, convStart_next;
  logic            irqSvc_reg, irqSvc_next;

  localparam logic [CNT_W-1:0] STARTUP_LEN = CNT_W'(STARTUP_CYCLES);
  localparam logic [CNT_W-1:0] STANDBY_LEN = CNT_W'(STANDBY_WAKE_CYC);
  localparam logic [CNT_W-1:0] HALT_LEN    = CNT_W'(WAKE_HALT_CYCLES);

  always_comb begin
    state_next     = state_reg;
    cnt_next       = cnt_reg;
    mode_next      = mode_reg;
    irqPend_next   = irqPend_reg;
    convStart_next = 1'b0;
    irqSvc_next    = 1'b0;
    unique case (state_reg)
      ST_RUN: begin
        if (sleepInstr && sleepArmBit && modeValid) begin
          state_next     = ST_SLEEP;
          mode_next      = effMode;
          convStart_next = converterEn && (effMode == MODE_NOISE_RED);
        end
      end
      ST_SLEEP: begin
        if (wakeEvent) begin
          irqPend_next = irqWake & ~wakeIn.resetReq;
          state_next   = ST_STARTUP;
          // Clocked modes need no restart; deep modes wait for the oscillator
          unique case (mode_reg)
            MODE_IDLE, MODE_NOISE_RED: cnt_next = CNT_W'(1);
            MODE_STANDBY: cnt_next = STANDBY_LEN;
            default: cnt_next = STARTUP_LEN;
          endcase
        end
      end
      ST_STARTUP: begin
        if (cnt_reg <= CNT_W'(1)) begin
          if (irqPend_reg) begin
            state_next = ST_HALT;
            cnt_next   = HALT_LEN;
          end else begin
            state_next = ST_RUN;
          end
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      ST_HALT: begin
        if (cnt_reg <= CNT_W'(1)) begin
          state_next   = ST_RUN;
          irqSvc_next  = 1'b1;
          irqPend_next = 1'b0;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= ST_RUN;
      cnt_reg       <= '0;
      mode_reg      <= MODE_IDLE;
      irqPend_reg   <= 1'b0;
      convStart_reg <= 1'b0;
      irqSvc_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      cnt_reg       <= cnt_next;
      mode_reg      <= mode_next;
      irqPend_reg   <= irqPend_next;
      convStart_reg <= convStart_next;
      irqSvc_reg    <= irqSvc_next;
    end
  end

  // ---------------------------------------------------------------
  // Power and clock outputs
  // ---------------------------------------------------------------
  smc_clk_en_t    clk_next;
  logic           sleeping;
  logic           compEn_next, refEn_next, bodEn_next, scanEn_next;
  logic [15:0]    bufEn_next;
  logic [15:0]    disMask;
  logic           convWasEn_reg, convExt_reg, convExt_next;

  assign sleeping = (state_next == ST_SLEEP);
  assign disMask  = {digitalInputDisableOne, digitalInputDisableZero};

  always_comb begin
    clk_next    = '1;
    compEn_next = ~comparatorPowerOffBit;
    if (sleeping) begin
      clk_next.cpuClk   = 1'b0;
      clk_next.flashClk = 1'b0;
      clk_next.timerOsc = timer2AsyncClockSelect;
      unique case (mode_next)
        MODE_IDLE: ;
        MODE_NOISE_RED: begin
          clk_next.ioClk    = 1'b0;
        end
        MODE_PWR_SAVE: begin
          clk_next = '0;
          clk_next.asyncClk = timer2AsyncClockSelect;
          clk_next.timerOsc = timer2AsyncClockSelect;
        end
        MODE_STANDBY: begin
          clk_next = '0;
          clk_next.mainOsc = 1'b1;
        end
        default: clk_next = '0;
      endcase
      if (onchipDebugEnableFuse) clk_next.mainOsc = 1'b1;
      // Comparator on the reference keeps it alive regardless of mode
      if (mode_next != MODE_IDLE && mode_next != MODE_NOISE_RED && !comparatorUsesRef)
        compEn_next = 1'b0;
    end
    bodEn_next  = (brownoutLevelFuses != BOD_DISABLED);
    refEn_next  = bodEn_next | (compEn_next & comparatorUsesRef) | converterEn;
    bufEn_next  = ~disMask;
    if (!clk_next.ioClk && !clk_next.convClk)
      bufEn_next = ~disMask & wakeNeededPins;
    scanEn_next = scanPortEnableFuse & ~scanPortDisableBit;
  end

  // Extended conversion after converter power cycles
  always_comb begin
    convExt_next = convExt_reg;
    if (converterEn && !convWasEn_reg) convExt_next = 1'b1;
    else if (convStart_next) convExt_next = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkEnOut        <= '1;
      converterEnOut  <= 1'b0;
      convWasEn_reg   <= 1'b0;
      convExt_reg     <= 1'b1;
      comparatorEnOut <= 1'b0;
      refEnOut        <= 1'b0;
      brownoutEnOut   <= 1'b0;
      watchdogEnOut   <= 1'b0;
      inputBufEnOut   <= '1;
      scanPortEnOut   <= 1'b0;
      tdoOut          <= 1'b0;
      tdoOe           <= 1'b0;
      cpuHaltOut      <= 1'b0;
      irqServiceOut   <= 1'b0;
      activeModeOut   <= MODE_IDLE;
      convStartOut    <= 1'b0;
    end else begin
      clkEnOut        <= clk_next;
      converterEnOut  <= converterEn;
      convWasEn_reg   <= converterEn;
      convExt_reg     <= convExt_next;
      comparatorEnOut <= compEn_next;
      refEnOut        <= refEn_next;
      brownoutEnOut   <= bodEn_next;
      watchdogEnOut   <= watchdogEn;
      inputBufEnOut   <= bufEn_next;
      scanPortEnOut   <= scanEn_next;
      tdoOut          <= tapTdoData;
      tdoOe           <= scanEn_next & tapShifting;
      cpuHaltOut      <= (state_next != ST_RUN);
      irqServiceOut   <= irqSvc_next;
      activeModeOut   <= mode_next;
      convStartOut    <= convStart_next;
    end
  end

  assign convExtendedOut = convExt_reg;

endmodule : smc_sleep_ctrl

//--- hw/smc_pkg.sv
package smc_pkg;

  // ---------------------------------------------------------------
  // Sleep mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_IDLE      = 3'h0;
  localparam logic [2:0] MODE_NOISE_RED = 3'h1;
  localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
  localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
  localparam logic [2:0] MODE_STANDBY   = 3'h6;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 10;
  localparam int WAKE_HALT_CYCLES  = 4;
  localparam int STANDBY_WAKE_CYC  = 6;
  localparam int STARTUP_DEFAULT   = 16;
  localparam int CNT_W             = 16;

  // ---------------------------------------------------------------
  // Field widths and brown-out off code
  // ---------------------------------------------------------------
  localparam int EXT_IRQ_W = 8;
  localparam int DIDR_W    = 8;
  localparam logic [2:0] BOD_DISABLED = 3'h7;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STARTUP,
    ST_HALT
  } smc_state_t;

  // Clock and oscillator enables, one bit each
  typedef struct packed {
    logic cpuClk;
    logic flashClk;
    logic ioClk;
    logic convClk;
    logic asyncClk;
    logic mainOsc;
    logic timerOsc;
  } smc_clk_en_t;

  // Wake source inputs, all active high
  typedef struct packed {
    logic [EXT_IRQ_W-1:0] extIrqEdge;
    logic [EXT_IRQ_W-1:0] extIrqLevel;
    logic                 twiMatch;
    logic                 timer2Ovf;
    logic                 timer2Cmp;
    logic                 selfProgReady;
    logic                 eepromReady;
    logic                 convDone;
    logic                 otherIo;
    logic                 resetReq;
  } smc_wake_t;

endpackage : smc_pkg

//--- bench/smc_sleep_ctrl_sva.sv
`timescale 1ns/1ns
module smc_sleep_ctrl_sva
  import smc_pkg::*;
(
  input wire logic        clk,                     // Clock
  input wire logic        rst_n,                   // Reset, low
  input wire logic        sleepInstr,              // Sleep pulse
  input wire logic        sleepArmBit,             // Arm bit
  input wire logic [2:0]  sleepModeCode,           // Mode
  input wire logic [2:0]  brownoutLevelFuses,      // BOD level
  input wire logic        watchdogEn,              // Watchdog on
  input wire logic        scanPortEnableFuse,      // Scan fuse
  input wire logic        scanPortDisableBit,      // Scan off
  input wire logic        tapShifting,             // Shifting
  input wire logic [7:0]  digitalInputDisableZero, // Disable 0
  input wire logic [7:0]  digitalInputDisableOne,  // Disable 1
  input wire smc_clk_en_t clkEnOut,                // Clocks
  input wire logic        comparatorEnOut,         // Comparator
  input wire logic        converterEnOut,          // Converter
  input wire logic        refEnOut,                // Reference
  input wire logic        brownoutEnOut,           // BOD
  input wire logic        watchdogEnOut,           // Watchdog
  input wire logic [15:0] inputBufEnOut,           // Buffers
  input wire logic        scanPortEnOut,           // Scan port
  input wire logic        tdoOe,                   // TDO drive
  input wire logic        cpuHaltOut               // Halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ---------------------------------------------------------------
  // Port relations
  // ---------------------------------------------------------------
  property p_bod; brownoutLevelFuses != BOD_DISABLED |=> brownoutEnOut; endproperty
  a_bod: assert property (p_bod) else $error("brown-out detector dropped");
  property p_wdt; watchdogEn |=> watchdogEnOut; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog dropped");
  // One cycle of slack lets the reference follow its users
  property p_ref;
    !(brownoutEnOut || comparatorEnOut || converterEnOut) [*2] |-> !refEnOut;
  endproperty
  a_ref: assert property (p_ref) else $error("reference on without user");
  property p_scan;
    !scanPortEnableFuse || scanPortDisableBit |=> !scanPortEnOut && !tdoOe;
  endproperty
  a_scan: assert property (p_scan) else $error("scan port not disabled");
  property p_tdo; !tapShifting |=> !tdoOe; endproperty
  a_tdo: assert property (p_tdo) else $error("tdo driven while idle");
  property p_buf;
    1'b1 |=> (inputBufEnOut & $past({digitalInputDisableOne, digitalInputDisableZero}))
             == 16'h0000;
  endproperty
  a_buf: assert property (p_buf) else $error("disabled buffer on");
  property p_pdn;
    sleepInstr && sleepArmBit && sleepModeCode == MODE_PWR_DOWN && !cpuHaltOut |=>
      cpuHaltOut && !clkEnOut.cpuClk && !clkEnOut.ioClk && !clkEnOut.convClk;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down entry wrong");
  property p_rsv;
    sleepInstr && sleepModeCode[2] && sleepModeCode != MODE_STANDBY && !cpuHaltOut |=>
      !cpuHaltOut && clkEnOut.cpuClk;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code slept");
endmodule : smc_sleep_ctrl_sva

bind smc_sleep_ctrl smc_sleep_ctrl_sva u_sva (.*);

//--- bench/smc_core_model.sv
`timescale 1ns/1ns
module smc_core_model
  import smc_pkg::*;
(
  input  wire logic clk,           // Clock
  input  wire logic cpuHaltOut,    // Halted
  input  wire logic irqServiceOut, // Interrupt resume
  input  wire logic asyncSel,      // Timer 2 async
  output smc_wake_t wakeIn,        // Wake sources
  output logic      sleepInstr,    // Sleep pulse
  output logic      sleepArmBit,   // Arm bit
  output logic [2:0] sleepModeCode // Mode
);
  initial begin
    wakeIn = '0;
    sleepInstr = 1'b0;
    sleepArmBit = 1'b0;
    sleepModeCode = MODE_IDLE;
  end

  task automatic sleep_req(input logic arm, input logic [2:0] mode);
    logic [2:0] m;
    m = mode;
    // Power-save without async timer corrupts timer state
    if (m == MODE_PWR_SAVE && !asyncSel) m = MODE_PWR_DOWN;
    @(posedge clk);
    sleepArmBit <= arm;
    sleepModeCode <= m;
    sleepInstr <= 1'b1;
    @(posedge clk);
    sleepInstr <= 1'b0;
    sleepArmBit <= 1'b0;
  endtask : sleep_req

  task automatic wake(input smc_wake_t w, input int lim, output int n, output logic s);
    n = 0;
    s = 1'b0;
    @(posedge clk);
    // Level held until the core is back or lim cycles pass, not a short blip
    wakeIn <= w;
    while (cpuHaltOut !== 1'b0 && n < lim) begin
      @(posedge clk);
      n++;
      if (irqServiceOut === 1'b1) s = 1'b1;
    end
    wakeIn <= '0;
  endtask : wake
endmodule : smc_core_model

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench
  import smc_pkg::*;
;
  localparam int STARTUP = 2;
  localparam int LIMIT = 5000;
  localparam smc_wake_t EXT0 = '{extIrqEdge: 8'h01, default: '0};
  localparam smc_wake_t OTHER = '{otherIo: 1'b1, default: '0};
  localparam smc_wake_t T2OVF = '{timer2Ovf: 1'b1, default: '0};
  localparam smc_wake_t CDONE = '{convDone: 1'b1, default: '0};
  typedef struct packed {logic [2:0] mode; logic xtal; logic dbg; smc_clk_en_t clk;} smc_row_t;
  smc_row_t rows [7] = '{
    '{MODE_IDLE, 1'b1, 1'b0, 7'h1f}, '{MODE_NOISE_RED, 1'b1, 1'b0, 7'h0f},
    '{MODE_PWR_DOWN, 1'b1, 1'b0, 7'h00}, '{MODE_PWR_SAVE, 1'b1, 1'b0, 7'h05},
    '{MODE_STANDBY, 1'b1, 1'b0, 7'h02}, '{MODE_STANDBY, 1'b0, 1'b0, 7'h00},
    '{MODE_PWR_DOWN, 1'b1, 1'b1, 7'h02}};
  logic [2:0] rsvd [4] = '{3'h4, 3'h5, 3'h7, MODE_PWR_DOWN};
  logic clk = 1'b0, rst_n = 1'b0, sleepInstr, sleepArmBit, s, deep;
  logic [2:0] sleepModeCode, activeModeOut, expMode, brownoutLevelFuses = 3'h7;
  smc_wake_t wakeIn;
  smc_clk_en_t clkEnOut;
  logic crystalSelected = 1'b0, timer2AsyncClockSelect = 1'b1, timer2OvfIrqEn = 1'b0;
  logic timer2CmpIrqEn = 1'b0, globalIrqEn = 1'b1, converterEn = 1'b0, watchdogEn = 1'b0;
  logic comparatorPowerOffBit = 1'b0, comparatorUsesRef = 1'b0, onchipDebugEnableFuse = 1'b0;
  logic scanPortEnableFuse = 1'b0, scanPortDisableBit = 1'b0;
  logic tapShifting = 1'b0, tapTdoData = 1'b0;
  logic [7:0] digitalInputDisableZero = 8'h0f, digitalInputDisableOne = 8'h00;
  logic [15:0] wakeNeededPins = 16'h0103, inputBufEnOut;
  logic converterEnOut, convStartOut, convExtendedOut, comparatorEnOut, refEnOut, brownoutEnOut;
  logic watchdogEnOut, scanPortEnOut, tdoOut, tdoOe, cpuHaltOut, irqServiceOut;
  int fails = 0, compares = 0, cyc = 0, n, convStarts = 0, convBase = 0;

  smc_sleep_ctrl #(.STARTUP_CYCLES(STARTUP)) dut (.*);
  smc_core_model cpu (.asyncSel(timer2AsyncClockSelect), .*);

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  always @(posedge clk) begin
    cyc++;
    if (convStartOut === 1'b1) convStarts++;
    if (cyc == LIMIT) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic complete_run;
    if (fails == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    tick(8);
    chk({clkEnOut, cpuHaltOut, inputBufEnOut, tdoOe, convExtendedOut},
        {7'h7f, 1'b0, 16'hffff, 1'b0, 1'b1});
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      crystalSelected <= rows[i].xtal;
      onchipDebugEnableFuse <= rows[i].dbg;
      cpu.sleep_req(1'b1, rows[i].mode);
      tick(2);
      deep = !rows[i].clk.ioClk && !rows[i].clk.convClk;
      expMode = (rows[i].mode == MODE_STANDBY && !rows[i].xtal) ? MODE_PWR_DOWN : rows[i].mode;
      chk({cpuHaltOut, clkEnOut, activeModeOut},
          {1'b1, rows[i].clk, expMode});
      chk(inputBufEnOut, deep ? 16'h0100 : 16'hfff0);
      // No reference user here: detector fused off, converter off, comparator on pins
      chk({comparatorEnOut, refEnOut}, {!deep, 1'b0});
      cpu.wake(EXT0, 60, n, s);
      chk({s, clkEnOut}, {1'b1, 7'h7f});
    end
    onchipDebugEnableFuse <= 1'b0;
    foreach (rsvd[i]) begin
      cpu.sleep_req(i < 3, rsvd[i]);
      tick(2);
      chk(cpuHaltOut, 1'b0);
    end
    cpu.sleep_req(1'b1, MODE_PWR_DOWN);
    cpu.wake(OTHER, 10, n, s);
    chk(cpuHaltOut, 1'b1);
    cpu.wake(EXT0, 60, n, s);
    chk(n >= STARTUP + WAKE_HALT_CYCLES && n <= STARTUP + WAKE_HALT_CYCLES + 3, 1'b1);
    cpu.sleep_req(1'b1, MODE_STANDBY);
    cpu.wake(EXT0, 60, n, s);
    chk(n >= STANDBY_WAKE_CYC + 4 && n <= STANDBY_WAKE_CYC + 7, 1'b1);
    cpu.sleep_req(1'b1, MODE_PWR_SAVE);
    cpu.wake(T2OVF, 10, n, s);
    chk(cpuHaltOut, 1'b1);
    timer2OvfIrqEn <= 1'b1;
    cpu.wake(T2OVF, 60, n, s);
    chk(s, 1'b1);
    converterEn <= 1'b1;
    watchdogEn <= 1'b1;
    brownoutLevelFuses <= 3'h2;
    convBase = convStarts;
    tick(3);
    chk(convExtendedOut, 1'b1);
    cpu.sleep_req(1'b1, MODE_NOISE_RED);
    cpu.wake(OTHER, 10, n, s);
    chk({(convStarts == convBase + 1), cpuHaltOut, converterEnOut, watchdogEnOut,
         brownoutEnOut, refEnOut}, 6'h3f);
    cpu.wake(CDONE, 60, n, s);
    chk({s, convExtendedOut}, 2'b10);
    converterEn <= 1'b0;
    tick(3);
    converterEn <= 1'b1;
    tick(3);
    chk(convExtendedOut, 1'b1);
    scanPortEnableFuse <= 1'b1;
    tapShifting <= 1'b1;
    tapTdoData <= 1'b1;
    tick(3);
    chk({scanPortEnOut, tdoOe, tdoOut}, 3'h7);
    tapShifting <= 1'b0;
    tick(3);
    chk(tdoOe, 1'b0);
    scanPortDisableBit <= 1'b1;
    tick(3);
    chk(scanPortEnOut, 1'b0);
    complete_run();
  end
endmodule : testbench
